// ==== ccg_clock_ctrl.sv ====
// Function
// - Outputs run while gate pin low
// - Disabled output holds high, low or released
// - Output starts on its first leading edge
// - Running cycle completes before output stops
// - Override pin low turns spreading off
// - Spreading only on first loop outputs
// - Alert pin low on loss or unlock
// - Each alert source has mask bit
// - Status readable by host any time
// - Each loop selects crystal or external
// - Each divider selects first or second loop
// - Tuning path only via second loop
// - Integer divider follows each fractional divider
// - Input divider keeps loop input at or below 30MHz for references up to 100MHz
// - Status bits 3,4 hold loss flags, 6:5 unlock flags, 7 range flag
`timescale 1ns/1ps
`default_nettype none
module ccg_clock_ctrl (
  input  wire logic                       mclk,
  input  wire logic                       reset,
  // AXI4-Lite slave
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [ccg_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                       wvalid,
  output logic                            wready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  output logic                            bvalid,
  input  wire logic                       bready,
  output logic [1:0]                      bresp,
  input  wire logic                       arvalid,
  output logic                            arready,
  input  wire logic [ccg_pkg::ADDR_W-1:0] araddr,
  output logic                            rvalid,
  input  wire logic                       rready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  // Pins and analog status
  input  wire logic                       outputGateLowPin_n,
  input  wire logic                       spreadOverridePin,
  input  wire logic                       crystalSignalLost,
  input  wire logic                       extRefSignalLost,
  input  wire logic                       firstLoopUnlocked,
  input  wire logic                       secondLoopUnlocked,
  input  wire logic [ccg_pkg::NOUT-1:0]   msFirstTick,
  input  wire logic [ccg_pkg::NOUT-1:0]   msSecondTick,
  input  wire logic [ccg_pkg::NOUT-1:0]   msTuneTick,
  input  wire logic                       faultAlertPinIn,
  output logic                            faultAlertPinOut,
  output logic                            faultAlertPinOe,
  output logic                            irq,
  output logic [ccg_pkg::NOUT-1:0]        outClk,
  output logic [ccg_pkg::NOUT-1:0]        outClkOe,
  output logic [ccg_pkg::NOUT-1:0]        spreadActive,
  output logic [ccg_pkg::NOUT-1:0]        msSrcSecond,
  output logic                            firstLoopRefExt,
  output logic                            secondLoopRefExt,
  output logic [1:0]                      extRefDivCode
);
  // Bus channel holding registers
  logic                       awHeld_q;   // Write address waiting
  logic [ccg_pkg::ADDR_W-1:0] awAddr_q;   // Held write address
  logic                       wHeld_q;    // Write data waiting
  logic [31:0]                wData_q;    // Held write data
  logic [3:0]                 wStrb_q;    // Held byte strobes
  logic                       bvalid_q;   // Write answer pending
  logic [1:0]                 bresp_q;    // Write answer code
  logic                       rvalid_q;   // Read answer pending
  logic [31:0]                rdata_q;    // Read answer data
  logic [1:0]                 rresp_q;    // Read answer code
  // Software registers
  logic [ccg_pkg::EV_W-1:0]   sticky_q, sticky_d;  // Sticky events
  logic [ccg_pkg::EV_W-1:0]   mask_q;              // One masks an event
  logic [1:0]                 refSel_q;            // Bit per loop, one is external
  logic [6:0]                 extMhz_q;            // External reference MHz
  logic [ccg_pkg::CFG_W-1:0]  outCfg_q [ccg_pkg::NOUT]; // Output configs
  // Derived state
  logic                       alert_q;    // Alert level
  logic [1:0]                 divCode_q;  // Input divider code
  logic [ccg_pkg::NOUT-1:0]   spread_q;   // Spreading per output
  logic [ccg_pkg::NOUT-1:0]   srcSec_q;   // Second loop per output
  // Decode and helper wires
  logic                       doWrite;    // Both halves held
  logic [31:0]                wMask;      // Bit mask from strobes
  logic                       wSticky, wMaskSel, wRefSel, wExt, wOut;
  logic [2:0]                 wIdx;       // Output index of write
  logic                       rHit;       // Read address mapped
  logic [31:0]                rMux;       // Read data selection
  logic [2:0]                 rIdx;       // Output index of read
  logic [ccg_pkg::EV_W-1:0]   evLive;     // Live conditions
  logic [ccg_pkg::EV_W-1:0]   clrBits;    // Write one to clear
  logic                       rangeBad;   // Reference outside 10..100 MHz
  logic [1:0]                 divCode_d;
  logic                       wHit;

  // Handshake outputs
  assign awready = !awHeld_q;
  assign wready  = !wHeld_q;
  assign arready = !rvalid_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

  // Write decode
  assign doWrite  = awHeld_q && wHeld_q && !bvalid_q;
  assign wMask    = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
  assign wSticky  = (awAddr_q == ccg_pkg::ADDR_STICKY);
  assign wMaskSel = (awAddr_q == ccg_pkg::ADDR_MASK);
  assign wRefSel  = (awAddr_q == ccg_pkg::ADDR_REFSEL);
  assign wExt     = (awAddr_q == ccg_pkg::ADDR_EXTREF);
  assign wOut     = (awAddr_q[7:5] == ccg_pkg::ADDR_OUTCFG) && (awAddr_q[1:0] == 2'h0);
  assign wIdx     = awAddr_q[4:2];
  assign wHit     = wSticky || wMaskSel || wRefSel || wExt || wOut
                    || (awAddr_q == ccg_pkg::ADDR_STATUS);
  assign rIdx     = araddr[4:2];

  // Live conditions in status layout
  assign rangeBad = (extMhz_q < ccg_pkg::EXT_MIN) || (extMhz_q > ccg_pkg::EXT_MAX);
  assign evLive   = {rangeBad, secondLoopUnlocked, firstLoopUnlocked,
                     extRefSignalLost, crystalSignalLost};

  // Read selection
  always_comb begin
    rHit = 1'b1;
    rMux = 32'h0000_0000;
    if (araddr == ccg_pkg::ADDR_STATUS) begin
      rMux[ccg_pkg::STAT_LSB +: ccg_pkg::EV_W] = evLive;
    end else if (araddr == ccg_pkg::ADDR_STICKY) begin
      rMux[ccg_pkg::STAT_LSB +: ccg_pkg::EV_W] = sticky_q;
    end else if (araddr == ccg_pkg::ADDR_MASK) begin
      rMux[ccg_pkg::STAT_LSB +: ccg_pkg::EV_W] = mask_q;
    end else if (araddr == ccg_pkg::ADDR_REFSEL) begin
      rMux[1:0] = refSel_q;
    end else if (araddr == ccg_pkg::ADDR_EXTREF) begin
      rMux[6:0] = extMhz_q;
      rMux[9:8] = divCode_q;
    end else if (araddr[7:5] == ccg_pkg::ADDR_OUTCFG && araddr[1:0] == 2'h0) begin
      rMux[ccg_pkg::CFG_W-1:0] = outCfg_q[rIdx];
    end else begin
      rHit = 1'b0;
    end
  end

  // Bus channel state
  always_ff @(posedge mclk) begin
    if (reset) begin
      awHeld_q <= 1'b0;
      awAddr_q <= '0;
      wHeld_q  <= 1'b0;
      wData_q  <= 32'h0000_0000;
      wStrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= ccg_pkg::RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= ccg_pkg::RESP_OKAY;
    end else begin
      // Take address and data in either order
      if (awvalid && awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= awaddr;
      end else if (doWrite) begin
        awHeld_q <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld_q <= 1'b1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end else if (doWrite) begin
        wHeld_q <= 1'b0;
      end
      // Write answer
      if (doWrite) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wHit ? ccg_pkg::RESP_OKAY : ccg_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid_q <= 1'b0;
      end
      // Read answer
      if (arvalid && arready) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rMux;
        rresp_q  <= rHit ? ccg_pkg::RESP_OKAY : ccg_pkg::RESP_SLVERR;
      end else if (rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Sticky events, a new event wins over a clear
  assign clrBits  = (doWrite && wSticky)
                  ? (wData_q[ccg_pkg::STAT_LSB +: ccg_pkg::EV_W]
                     & wMask[ccg_pkg::STAT_LSB +: ccg_pkg::EV_W])
                  : '0;
  assign sticky_d = (sticky_q & ~clrBits) | evLive;

  // Input divider picks smallest ratio that keeps loop input in range for references up to 100 MHz
  assign divCode_d = (extMhz_q <= ccg_pkg::PLL_MAX)  ? ccg_pkg::EXT_DIV1
                   : (extMhz_q <= ccg_pkg::DIV2_MAX) ? ccg_pkg::EXT_DIV2
                   : ccg_pkg::EXT_DIV4;

  // Configuration and status registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      sticky_q  <= '0;
      mask_q    <= ccg_pkg::MASK_RST;
      refSel_q  <= ccg_pkg::REFSEL_RST;
      extMhz_q  <= ccg_pkg::EXT_RST;
      alert_q   <= 1'b0;
      divCode_q <= ccg_pkg::EXT_DIV1;
    end else begin
      sticky_q  <= sticky_d;
      alert_q   <= |(sticky_q & ~mask_q);
      divCode_q <= divCode_d;
      if (doWrite && wMaskSel) begin
        mask_q <= (mask_q & ~wMask[ccg_pkg::STAT_LSB +: ccg_pkg::EV_W])
                | (wData_q[ccg_pkg::STAT_LSB +: ccg_pkg::EV_W]
                   & wMask[ccg_pkg::STAT_LSB +: ccg_pkg::EV_W]);
      end
      if (doWrite && wRefSel && wStrb_q[0]) begin
        refSel_q <= wData_q[1:0];
      end
      if (doWrite && wExt && wStrb_q[0]) begin
        extMhz_q <= wData_q[6:0];
      end
    end
  end

  // Open-drain alert: drive low while any unmasked event stands
  assign faultAlertPinOut = 1'b0;
  assign faultAlertPinOe  = alert_q;
  assign irq              = alert_q;
  assign firstLoopRefExt  = refSel_q[0];
  assign secondLoopRefExt = refSel_q[1];
  assign extRefDivCode    = divCode_q;
  assign spreadActive     = spread_q;
  assign msSrcSecond      = srcSec_q;

  // Per-output routing, spreading and gate
  genvar i;
  generate
    for (i = 0; i < ccg_pkg::NOUT; i++) begin : gOut
      ccg_gate_if gIf ();
      logic effSecond;
      logic tune;
      // Tuning path is reachable only through the second loop
      assign tune      = outCfg_q[i][ccg_pkg::CFG_TUNE];
      assign effSecond = outCfg_q[i][ccg_pkg::CFG_SECOND] || tune;
      assign gIf.srcTick  = tune ? msTuneTick[i]
                          : (effSecond ? msSecondTick[i] : msFirstTick[i]);
      assign gIf.rdivExp  = outCfg_q[i][ccg_pkg::CFG_RDIV +: 3];
      assign gIf.disState = ccg_pkg::ccg_dis_t'(outCfg_q[i][ccg_pkg::CFG_DIS +: 2]);
      assign gIf.enable   = !outputGateLowPin_n;
      assign outClk[i]    = gIf.clkOut;
      assign outClkOe[i]  = gIf.clkOe;
      // Output config and registered routing
      always_ff @(posedge mclk) begin
        if (reset) begin
          outCfg_q[i] <= ccg_pkg::CFG_RST;
          spread_q[i] <= 1'b0;
          srcSec_q[i] <= 1'b0;
        end else begin
          if (doWrite && wOut && wIdx == 3'(i) && wStrb_q[0]) begin
            outCfg_q[i] <= wData_q[ccg_pkg::CFG_W-1:0];
          end
          spread_q[i] <= outCfg_q[i][ccg_pkg::CFG_SPREAD] && !effSecond
                         && spreadOverridePin;
          srcSec_q[i] <= effSecond;
        end
      end
      ccg_out_gate uGate (
        .mclk  (mclk),
        .reset (reset),
        .g     (gIf.gate)
      );
    end
  endgenerate

  // Events are caught in the sticky register
  property p_sticky_set;
    @(posedge mclk) disable iff (reset)
      (evLive != '0) |=> ((sticky_q & $past(evLive)) == $past(evLive));
  endproperty
  a_sticky_set: assert property (p_sticky_set)
    else $error("event lost from sticky status");
  // Unmasked event drives the alert
  property p_alert_on;
    @(posedge mclk) disable iff (reset) (|(sticky_q & ~mask_q)) |=> faultAlertPinOe;
  endproperty
  a_alert_on: assert property (p_alert_on)
    else $error("alert not driven for unmasked event");
  // Masked events leave the alert released
  property p_alert_off;
    @(posedge mclk) disable iff (reset) ((sticky_q & ~mask_q) == '0) |=> !faultAlertPinOe;
  endproperty
  a_alert_off: assert property (p_alert_off)
    else $error("alert driven by masked event");
  // Status read returns the live conditions
  property p_status_read;
    @(posedge mclk) disable iff (reset)
      (arvalid && arready && araddr == ccg_pkg::ADDR_STATUS)
      |=> rvalid && rdata[ccg_pkg::STAT_LSB +: ccg_pkg::EV_W] == $past(evLive);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read wrong");
  // Override pin low kills all spreading
  property p_spread_off;
    @(posedge mclk) disable iff (reset) !spreadOverridePin |=> (spreadActive == '0);
  endproperty
  a_spread_off: assert property (p_spread_off)
    else $error("spreading during override");
  // No spreading on second loop outputs
  property p_spread_first;
    @(posedge mclk) disable iff (reset) (spreadActive & msSrcSecond) == '0;
  endproperty
  a_spread_first: assert property (p_spread_first)
    else $error("spreading on second loop output");
  // Loop input within limit for valid reference
  property p_div_limit;
    @(posedge mclk) disable iff (reset)
      ($past(extMhz_q) <= ccg_pkg::EXT_MAX) |-> (($past(extMhz_q) >> extRefDivCode) <= ccg_pkg::PLL_MAX);
  endproperty
  a_div_limit: assert property (p_div_limit)
    else $error("loop input above limit");
  // Written selector reaches the loop inputs
  property p_refsel_write;
    @(posedge mclk) disable iff (reset)
      (doWrite && wRefSel && wStrb_q[0])
      |=> ({secondLoopRefExt, firstLoopRefExt} == $past(wData_q[1:0]));
  endproperty
  a_refsel_write: assert property (p_refsel_write)
    else $error("reference selector not updated");
  // Cleared events leave the sticky register when no event stands
  property p_sticky_clear;
    @(posedge mclk) disable iff (reset)
      (doWrite && wSticky && (evLive == '0)) |=> ((sticky_q & $past(clrBits)) == '0);
  endproperty
  a_sticky_clear: assert property (p_sticky_clear)
    else $error("sticky event survived its clear");
endmodule
`default_nettype wire

// ==== ccg_far_side.sv ====
`timescale 1ns/1ps
`default_nettype none
// Downstream model: divider tick source and pulled-up alert wire
module ccg_far_side (
  input  wire logic       mclk,
  input  wire logic       reset,
  output logic [7:0]      tickOut,
  input  wire logic       alertOe,
  input  wire logic       alertOut,
  output logic            alertLevel
);
  logic [1:0] cnt_q;  // Tick spacing counter
  // One-cycle tick every fourth clock
  always_ff @(posedge mclk) begin
    cnt_q <= reset ? 2'h0 : cnt_q + 2'h1;
  end
  // One shared tick rate keeps the distinct fast rates within two
  assign tickOut = {8{cnt_q == 2'h3}};
  // Pull-up wins unless the pin is pulled down
  assign alertLevel = alertOe ? alertOut : 1'b1;
endmodule
`default_nettype wire

// ==== ccg_gate_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Per-output link between control and gate
interface ccg_gate_if;
  logic             srcTick;   // Divider output tick
  logic [2:0]       rdivExp;   // Output divide exponent
  ccg_pkg::ccg_dis_t disState; // State while disabled
  logic             enable;    // Output wanted
  logic             clkOut;    // Gated clock level
  logic             clkOe;     // Pin driven
  logic             running;   // Gate open
  modport ctl  (output srcTick, rdivExp, disState, enable, input clkOut, clkOe, running);
  modport gate (input srcTick, rdivExp, disState, enable, output clkOut, clkOe, running);
endinterface
`default_nettype wire

// ==== ccg_out_gate.sv ====
`timescale 1ns/1ps
`default_nettype none
// Output divider and glitchless gate for one output
module ccg_out_gate (
  input wire logic mclk,
  input wire logic reset,
  ccg_gate_if.gate g
);
  logic [6:0]         cnt_q, cnt_d;       // Tick count in half period
  logic               divClk_q, divClk_d; // Divided clock
  ccg_pkg::ccg_gate_t state_q, state_d;   // Gate state
  logic               clkOut_q, clkOut_d; // Registered pin level
  logic               clkOe_q, clkOe_d;   // Registered pin enable
  logic [6:0]         halfM1;             // Ticks per half minus one
  logic               wrap, rise;

  // Divide by 2^n, exponent zero treated as one
  assign halfM1 = (g.rdivExp == 3'h0) ? 7'h00
                : 7'((7'h01 << (g.rdivExp - 3'h1)) - 7'h01);
  assign wrap   = g.srcTick && (cnt_q == halfM1);
  assign rise   = wrap && !divClk_q;
  assign cnt_d  = !g.srcTick ? cnt_q : (wrap ? 7'h00 : 7'(cnt_q + 7'h01));
  assign divClk_d = wrap ? ~divClk_q : divClk_q;

  // Gate opens and closes only on a leading edge
  always_comb begin
    state_d = state_q;
    case (state_q)
      ccg_pkg::CCG_GATE_OFF: begin
        if (rise && g.enable) state_d = ccg_pkg::CCG_GATE_RUN;
      end
      default: begin
        if (rise && !g.enable) state_d = ccg_pkg::CCG_GATE_OFF;
      end
    endcase
  end

  // Pin level and enable, held state when closed
  assign clkOut_d = (state_d == ccg_pkg::CCG_GATE_RUN) ? divClk_d
                  : (g.disState == ccg_pkg::CCG_DIS_HIGH);
  assign clkOe_d  = (state_d == ccg_pkg::CCG_GATE_RUN)
                  || (g.disState == ccg_pkg::CCG_DIS_LOW)
                  || (g.disState == ccg_pkg::CCG_DIS_HIGH);

  // State registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_q    <= 7'h00;
      divClk_q <= 1'b0;
      state_q  <= ccg_pkg::CCG_GATE_OFF;
      clkOut_q <= 1'b0;
      clkOe_q  <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      divClk_q <= divClk_d;
      state_q  <= state_d;
      clkOut_q <= clkOut_d;
      clkOe_q  <= clkOe_d;
    end
  end

  assign g.clkOut  = clkOut_q;
  assign g.clkOe   = clkOe_q;
  assign g.running = (state_q == ccg_pkg::CCG_GATE_RUN);

  // Gate opens with the clock high
  property p_start_high;
    @(posedge mclk) disable iff (reset) $rose(g.running) |-> g.clkOut;
  endproperty
  a_start_high: assert property (p_start_high)
    else $error("output started mid pulse");
  // Gate closes only after a low half
  property p_stop_full;
    @(posedge mclk) disable iff (reset) $fell(g.running) |-> !$past(g.clkOut);
  endproperty
  a_stop_full: assert property (p_stop_full)
    else $error("output cut a cycle short");
  // High impedance when closed and so configured
  property p_hiz;
    @(posedge mclk) disable iff (reset)
      (!g.running && $past(g.disState) == ccg_pkg::CCG_DIS_HIZ) |-> !g.clkOe;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("disabled output still driven");
endmodule
`default_nettype wire

// ==== ccg_pkg.sv ====
`default_nettype none
// Shared constants of the clock gating and status block
package ccg_pkg;
  // Sizes
  localparam int NOUT   = 8;   // Clock outputs
  localparam int ADDR_W = 8;   // Bus address width
  localparam int EV_W   = 5;   // Status events
  localparam int CFG_W  = 8;   // Output config width
  // Byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'h00;  // Live status
  localparam logic [7:0] ADDR_STICKY = 8'h04;  // Sticky status, write one to clear
  localparam logic [7:0] ADDR_MASK   = 8'h08;  // Interrupt mask, one masks
  localparam logic [7:0] ADDR_REFSEL = 8'h0C;  // Loop reference selectors
  localparam logic [7:0] ADDR_EXTREF = 8'h10;  // External reference frequency in MHz
  localparam logic [2:0] ADDR_OUTCFG = 3'h1;   // Bits 7:5 of 0x20..0x3C
  // Status field position inside a status word
  localparam int STAT_LSB = 3;
  // Output config fields
  localparam int CFG_SECOND = 0;  // Divider fed by second loop
  localparam int CFG_SPREAD = 1;  // Spreading wanted
  localparam int CFG_DIS    = 2;  // Disabled state, 2 bits
  localparam int CFG_RDIV   = 4;  // Output divide exponent, 3 bits
  localparam int CFG_TUNE   = 7;  // Tuning voltage path
  localparam logic [CFG_W-1:0] CFG_RST = 8'h10;  // Divide by 2, low when off
  // Reset values
  localparam logic [EV_W-1:0] MASK_RST   = 5'h00;
  localparam logic [1:0]      REFSEL_RST = 2'h0;
  localparam logic [6:0]      EXT_RST    = 7'h19;  // 25 MHz
  // External reference limits in MHz
  localparam logic [6:0] EXT_MIN  = 7'h0A;  // 10
  localparam logic [6:0] EXT_MAX  = 7'h64;  // 100
  localparam logic [6:0] PLL_MAX  = 7'h1E;  // 30
  localparam logic [6:0] DIV2_MAX = 7'h3C;  // 60
  // Input divider codes, value is the shift
  localparam logic [1:0] EXT_DIV1 = 2'h0;
  localparam logic [1:0] EXT_DIV2 = 2'h1;
  localparam logic [1:0] EXT_DIV4 = 2'h2;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Disabled output states
  typedef enum logic [1:0] {
    CCG_DIS_LOW  = 2'b00,
    CCG_DIS_HIGH = 2'b01,
    CCG_DIS_HIZ  = 2'b10,
    CCG_DIS_HIZ2 = 2'b11
  } ccg_dis_t;
  // Gate states
  typedef enum logic {
    CCG_GATE_OFF = 1'b0,
    CCG_GATE_RUN = 1'b1
  } ccg_gate_t;
endpackage
`default_nettype wire

// ==== clock_output_gating_status_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module clock_output_gating_status_bench;
  logic mclk, reset, awvalid, wvalid, bready, arvalid, rready, gateN, ovr;
  logic xLost, eLost, aUnl, bUnl, alertOe, alertOut, alertLvl, irq, refA, refB;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr, tick, outClk, outOe, spr, src2;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs, divCode;
  int          failures, total_checks;
  // Clock and reset
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  ccg_clock_ctrl ccg_clock_ctrl_inst (.mclk(mclk), .reset(reset), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .outputGateLowPin_n(gateN), .spreadOverridePin(ovr),
    .crystalSignalLost(xLost), .extRefSignalLost(eLost), .firstLoopUnlocked(aUnl),
    .secondLoopUnlocked(bUnl), .msFirstTick(tick), .msSecondTick(tick), .msTuneTick(tick),
    .faultAlertPinIn(alertLvl), .faultAlertPinOut(alertOut), .faultAlertPinOe(alertOe),
    .irq(irq), .outClk(outClk), .outClkOe(outOe), .spreadActive(spr), .msSrcSecond(src2),
    .firstLoopRefExt(refA), .secondLoopRefExt(refB), .extRefDivCode(divCode));
  ccg_far_side ccg_far_side_inst (.mclk(mclk), .reset(reset), .tickOut(tick),
    .alertOe(alertOe), .alertOut(alertOut), .alertLevel(alertLvl));
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Bus write: address and data offered together, released as taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    awvalid <= 1; awaddr <= a; wvalid <= 1; wdata <= d; bready <= 1;
    do begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid && bready) begin
        rs = bresp;
        bready <= 0;
      end
    end while (awvalid || wvalid || bready);
  endtask
  // Bus read: rready held until data seen
  task automatic rdw(input logic [7:0] a);
    @(posedge mclk);
    arvalid <= 1; araddr <= a; rready <= 1;
    do begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid && rready) begin
        rd = rdata; rs = rresp;
        rready <= 0;
      end
    end while (arvalid || rready);
  endtask
  // Reset values, selectors and input divider
  task automatic t_regs();
    rdw(8'h08); chk("mask", rd, 32'h0);
    rdw(8'h20); chk("cfg0", rd, 32'h10);
    rdw(8'hFC); chk("unmapped", rs, 2'h2);
    wr(8'hFC, 32'h0);
    chk("wrBad", rs, 2'h2);
    wr(8'h0C, 32'h2);
    chk("wrOk", rs, 2'h0);
    repeat (2) @(posedge mclk);
    chk("refsel", {refB, refA}, 2'h2);
    wr(8'h10, 32'h64); rdw(8'h10); chk("ext100", rd, 32'h264);
    chk("divcode", divCode, 2'h2);
    wr(8'h10, 32'h1E); repeat (2) @(posedge mclk);
    chk("div30", divCode, 2'h0);
    wr(8'h10, 32'h05);
    rdw(8'h00);
    chk("range", rd, 32'h80);
    wr(8'h10, 32'h1E);
    wr(8'h04, 32'h80);
  endtask
  // Alert sources, sticky clear and masking
  task automatic t_alert();
    xLost <= 1; repeat (3) @(posedge mclk);
    rdw(8'h00); chk("live", rd, 32'h08);
    chk("irqOn", irq, 1'b1);
    chk("pinLow", alertLvl, 1'b0);
    xLost <= 0; rdw(8'h04); chk("sticky", rd, 32'h08);
    wr(8'h04, 32'h08); repeat (2) @(posedge mclk);
    chk("irqOff", irq, 1'b0);
    wr(8'h08, 32'h60); bUnl <= 1; aUnl <= 1; eLost <= 1; repeat (3) @(posedge mclk);
    chk("masked", irq, 1'b1);
    rdw(8'h00); chk("live2", rd, 32'h70);
    eLost <= 0; wr(8'h04, 32'h10); repeat (2) @(posedge mclk);
    chk("maskOk", irq, 1'b0);
    bUnl <= 0; aUnl <= 0; wr(8'h04, 32'h60);
  endtask
  // Spread gating by source and override pin
  task automatic t_spread();
    wr(8'h24, 32'h12); repeat (2) @(posedge mclk);
    chk("sprOn", spr[1], 1'b1);
    ovr <= 0; repeat (3) @(posedge mclk);
    chk("sprOvr", spr[1], 1'b0);
    ovr <= 1;
    repeat (2) @(posedge mclk);
    chk("sprBack", spr[1], 1'b1);
    wr(8'h24, 32'h13); repeat (2) @(posedge mclk);
    chk("src2", {src2[1], spr[1]}, 2'h2);
    wr(8'h24, 32'h92); repeat (2) @(posedge mclk);
    chk("tune", {src2[1], spr[1]}, 2'h2);
  endtask
  // Enable pin gating and disabled states
  task automatic t_gate();
    int   ups;
    logic prev;
    ups  = 0;
    prev = outClk[0];
    gateN <= 0;
    repeat (40) begin
      @(posedge mclk);
      if (outClk[0] && !prev) ups++;
      prev = outClk[0];
    end
    chk("running", (ups >= 4 && ups <= 5), 1'b1);
    gateN <= 1; repeat (30) @(posedge mclk);
    chk("stopLow", {outOe[0], outClk[0]}, 2'h2);
    wr(8'h20, 32'h14); repeat (30) @(posedge mclk);
    chk("stopHigh", {outOe[0], outClk[0]}, 2'h3);
    wr(8'h20, 32'h18); repeat (30) @(posedge mclk);
    chk("hiz", outOe[0], 1'b0);
  endtask
  // Watchdog
  initial begin
    #300000;
    failures++;
    test_done();
  end
  // Main sequence
  initial begin
    failures = 0; total_checks = 0;
    reset = 1; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = 0; araddr = 0; wdata = 0; gateN = 1; ovr = 1;
    xLost = 0; eLost = 0; aUnl = 0; bUnl = 0;
    repeat (5) @(posedge mclk);
    reset <= 0;
    t_regs();
    t_alert();
    t_spread();
    t_gate();
    test_done();
  end
endmodule
`default_nettype wire
